// >>> verilog/ufb_pkg.sv
// Constants, state type and helper for the fractional rate generator and transmitter.
// Assumes a single clock that stands for the oscillator input of one channel.
package ufb_pkg;
    // Register offsets on the byte-wide register port
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_DIVHI = 3'h1;
    localparam logic [2:0] OFS_DIVFRAC = 3'h2;
    localparam logic [2:0] OFS_LINECTL = 3'h3;
    localparam logic [2:0] OFS_MODEMCTL = 3'h4;
    localparam logic [2:0] OFS_LINESTAT = 3'h5;
    // Values after reset
    localparam logic [7:0] DIVLO_RST = 8'h01;
    localparam logic [7:0] DIVHI_RST = 8'h00;
    localparam logic [5:0] DIVFRAC_RST = 6'h00;
    localparam logic [7:0] LINECTL_RST = 8'h00;
    localparam logic [7:0] MODEMCTL_RST = 8'h00;
    // Field positions
    localparam int MCR_PRESCALE_BIT = 7;
    localparam int LCR_DLAB_BIT = 7;
    localparam int LCR_STOP_BIT = 2;
    localparam int LCR_PAREN_BIT = 3;
    localparam int LCR_PAREVEN_BIT = 4;
    localparam int LSR_THREMPTY_BIT = 5;
    localparam int LSR_TXEMPTY_BIT = 6;
    // Counts
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    localparam logic [20:0] ACC_STEP = 21'h10;
    localparam logic [1:0] MODE_8X = 2'h1;
    localparam logic [1:0] MODE_4X = 2'h2;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ufb_txst_t;

    // Sampling clocks per serial bit; pattern 11 falls back to 16X
    function automatic logic [5:0] ufb_bit_len(input logic [1:0] mode);
        case (mode)
            MODE_8X: ufb_bit_len = 6'h08;
            MODE_4X: ufb_bit_len = 6'h04;
            default: ufb_bit_len = 6'h10;
        endcase
    endfunction : ufb_bit_len
endpackage : ufb_pkg

// >>> verilog/ufb_fractional_baud_gen_tx.sv
// One channel: prescaler, fractional rate generator, transmit FIFO and shifter.
// Assumes the register port is driven synchronously to clk_sys; one instance per channel.
`timescale 1ns/1ns
`default_nettype none

//
// Function
// - Each channel instance owns its own prescaler and rate generator.
// - Modem control bit 7 picks prescaler divide by one or by four.
// - Bit set means divide by four, a quarter of the oscillator clock rate.
// - Generator divides prescaled clock by integer plus sixteenths to make sampling clock.
// - Reset gives divisor one: low 0x01, high 0x00, fraction 0x00.
// - Integer divisor is high byte over low byte.
// - Only four low fraction bits count, adding N sixteenths.
// - Fraction register bits 5:4 select 16X, 8X or 4X sampling.
// - Sampling clock times transmit shifting and is offered to the receiver.
// - Each bit lasts sixteen, eight or four sampling periods.
// - Odd fractions may jitter bit times by one prescaled clock period.
// - Eight-bit shifter fed by a sixteen-byte FIFO whose head is holding register.
// - Character is start, data bits, optional parity, then stop bits.
// - Line status bit 5 shows FIFO empty, bit 6 FIFO and shifter both empty.
// - Data goes out least significant bit first after start.
module ufb_fractional_baud_gen_tx (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic regCs,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Serial side
    output logic txOut,
    output logic sampleTick
);
    logic [7:0] divLo_ff;
    logic [7:0] divHi_ff;
    logic [5:0] divFrac_ff;
    logic [7:0] lineCtl_ff;
    logic [7:0] modemCtl_ff;
    logic [7:0] regRdData_ff;
    logic [7:0] nxt_rdData;
    logic [1:0] presCnt_ff;
    logic presTick;
    logic divWrite;
    logic [19:0] acc_ff;
    logic [20:0] accSum;
    logic [20:0] divFull;
    logic sampleTick_ff;
    logic [7:0] fifoMem [16];
    logic [3:0] wrPtr_ff;
    logic [3:0] rdPtr_ff;
    logic [4:0] fifoCount_ff;
    logic push;
    logic pop;
    logic dlab;
    ufb_pkg::ufb_txst_t txState_ff;
    logic [7:0] txShift_ff;
    logic [2:0] bitIdx_ff;
    logic [5:0] sampCnt_ff;
    logic [5:0] bitLen;
    logic [5:0] stopLen;
    logic [5:0] curLen;
    logic parity_ff;
    logic txOut_ff;
    logic [2:0] lastIdx;

    assign dlab = lineCtl_ff[ufb_pkg::LCR_DLAB_BIT];
    assign bitLen = ufb_pkg::ufb_bit_len(divFrac_ff[5:4]);
    assign lastIdx = {1'b0, lineCtl_ff[1:0]} + 3'h4;

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divLo_ff <= ufb_pkg::DIVLO_RST;
            divHi_ff <= ufb_pkg::DIVHI_RST;
            divFrac_ff <= ufb_pkg::DIVFRAC_RST;
            lineCtl_ff <= ufb_pkg::LINECTL_RST;
            modemCtl_ff <= ufb_pkg::MODEMCTL_RST;
        end else if (regCs && regWr) begin
            case (regAddr)
                ufb_pkg::OFS_DATA: if (dlab) divLo_ff <= regWrData;
                ufb_pkg::OFS_DIVHI: if (dlab) divHi_ff <= regWrData;
                ufb_pkg::OFS_DIVFRAC: if (dlab) divFrac_ff <= regWrData[5:0];
                ufb_pkg::OFS_LINECTL: lineCtl_ff <= regWrData;
                ufb_pkg::OFS_MODEMCTL: modemCtl_ff <= regWrData;
                default: ;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Register reads, answered one cycle later; no side effects
    // --------------------------------------------------------------
    always_comb begin
        nxt_rdData = 8'h00;
        case (regAddr)
            ufb_pkg::OFS_DATA: nxt_rdData = dlab ? divLo_ff : 8'h00;
            ufb_pkg::OFS_DIVHI: nxt_rdData = dlab ? divHi_ff : 8'h00;
            ufb_pkg::OFS_DIVFRAC: nxt_rdData = dlab ? {2'h0, divFrac_ff} : 8'h00;
            ufb_pkg::OFS_LINECTL: nxt_rdData = lineCtl_ff;
            ufb_pkg::OFS_MODEMCTL: nxt_rdData = modemCtl_ff;
            ufb_pkg::OFS_LINESTAT: begin
                nxt_rdData[ufb_pkg::LSR_THREMPTY_BIT] = (fifoCount_ff == 5'h00);
                nxt_rdData[ufb_pkg::LSR_TXEMPTY_BIT] = (fifoCount_ff == 5'h00)
                    && (txState_ff == ufb_pkg::TX_IDLE);
            end
            default: nxt_rdData = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regRdData_ff <= 8'h00;
        end else if (regCs && regRd) begin
            regRdData_ff <= nxt_rdData;
        end
    end

    // --------------------------------------------------------------
    // Prescaler and fractional rate generator
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            presCnt_ff <= 2'h0;
        end else begin
            presCnt_ff <= presCnt_ff + 2'h1;
        end
    end

    // Divide by one passes every edge, divide by four every fourth
    assign presTick = modemCtl_ff[ufb_pkg::MCR_PRESCALE_BIT] ?
        (presCnt_ff == ufb_pkg::PRESCALE_LAST) : 1'b1;

    // Divisor in sixteenths; accumulator adds sixteen per prescaled edge
    assign divFull = {1'b0, divHi_ff, divLo_ff, divFrac_ff[3:0]};
    assign accSum = {1'b0, acc_ff} + ufb_pkg::ACC_STEP;
    assign divWrite = regCs && regWr && dlab && (regAddr == ufb_pkg::OFS_DATA
        || regAddr == ufb_pkg::OFS_DIVHI || regAddr == ufb_pkg::OFS_DIVFRAC);

    // Odd fractions spread the remainder, so periods differ by one edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_ff <= 20'h00000;
            sampleTick_ff <= 1'b0;
        end else begin
            sampleTick_ff <= 1'b0;
            if (presTick) begin
                if (divFull <= ufb_pkg::ACC_STEP) begin
                    acc_ff <= 20'h00000;
                    sampleTick_ff <= 1'b1;
                end else if (accSum >= divFull) begin
                    acc_ff <= 20'(accSum - divFull);
                    sampleTick_ff <= 1'b1;
                end else begin
                    acc_ff <= accSum[19:0];
                end
            end
            // Divisor write restarts the count, else a stale remainder bursts ticks
            if (divWrite) begin
                acc_ff <= 20'h00000;
            end
        end
    end

    // --------------------------------------------------------------
    // Transmit FIFO; writes to a full FIFO are dropped
    // --------------------------------------------------------------
    assign push = regCs && regWr && (regAddr == ufb_pkg::OFS_DATA) && !dlab
        && (fifoCount_ff != ufb_pkg::FIFO_DEPTH);
    assign pop = (txState_ff == ufb_pkg::TX_IDLE) && (fifoCount_ff != 5'h00) && sampleTick_ff;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            fifoMem[wrPtr_ff] <= regWrData;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPtr_ff <= 4'h0;
            rdPtr_ff <= 4'h0;
            fifoCount_ff <= 5'h00;
        end else begin
            if (push) wrPtr_ff <= wrPtr_ff + 4'h1;
            if (pop) rdPtr_ff <= rdPtr_ff + 4'h1;
            if (push && !pop) fifoCount_ff <= fifoCount_ff + 5'h01;
            else if (pop && !push) fifoCount_ff <= fifoCount_ff - 5'h01;
        end
    end

    // --------------------------------------------------------------
    // Transmit shifter
    // --------------------------------------------------------------
    // Two stop bits become one and a half with five-bit words
    assign stopLen = !lineCtl_ff[ufb_pkg::LCR_STOP_BIT] ? bitLen :
        (lineCtl_ff[1:0] == 2'h0) ? 6'(bitLen + (bitLen >> 1)) : 6'(bitLen << 1);
    assign curLen = (txState_ff == ufb_pkg::TX_STOP) ? stopLen : bitLen;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txState_ff <= ufb_pkg::TX_IDLE;
            txShift_ff <= 8'h00;
            bitIdx_ff <= 3'h0;
            sampCnt_ff <= 6'h00;
            parity_ff <= 1'b0;
            txOut_ff <= 1'b1;
        end else if (sampleTick_ff) begin
            if (txState_ff != ufb_pkg::TX_IDLE && sampCnt_ff != 6'(curLen - 6'h01)) begin
                sampCnt_ff <= sampCnt_ff + 6'h01;
            end else begin
                sampCnt_ff <= 6'h00;
                case (txState_ff)
                    ufb_pkg::TX_IDLE: if (pop) begin
                        txShift_ff <= fifoMem[rdPtr_ff];
                        txOut_ff <= 1'b0;
                        parity_ff <= !lineCtl_ff[ufb_pkg::LCR_PAREVEN_BIT];
                        txState_ff <= ufb_pkg::TX_START;
                    end
                    ufb_pkg::TX_START: begin
                        txOut_ff <= txShift_ff[0];
                        parity_ff <= parity_ff ^ txShift_ff[0];
                        txShift_ff <= txShift_ff >> 1;
                        bitIdx_ff <= 3'h0;
                        txState_ff <= ufb_pkg::TX_DATA;
                    end
                    ufb_pkg::TX_DATA: begin
                        if (bitIdx_ff != lastIdx) begin
                            txOut_ff <= txShift_ff[0];
                            parity_ff <= parity_ff ^ txShift_ff[0];
                            txShift_ff <= txShift_ff >> 1;
                            bitIdx_ff <= bitIdx_ff + 3'h1;
                        end else if (lineCtl_ff[ufb_pkg::LCR_PAREN_BIT]) begin
                            txOut_ff <= parity_ff;
                            txState_ff <= ufb_pkg::TX_PARITY;
                        end else begin
                            txOut_ff <= 1'b1;
                            txState_ff <= ufb_pkg::TX_STOP;
                        end
                    end
                    ufb_pkg::TX_PARITY: begin
                        txOut_ff <= 1'b1;
                        txState_ff <= ufb_pkg::TX_STOP;
                    end
                    default: begin
                        txOut_ff <= 1'b1;
                        txState_ff <= ufb_pkg::TX_IDLE;
                    end
                endcase
            end
        end
    end

    assign regRdData = regRdData_ff;
    assign txOut = txOut_ff;
    assign sampleTick = sampleTick_ff;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    property p_reset_div;
        @(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> (divLo_ff == 8'h01 && divHi_ff == 8'h00 && divFrac_ff == 6'h00);
    endproperty
    a_reset_div: assert property (p_reset_div) else $error("divisor not one after reset");

    property p_pres_quarter;
        @(posedge clk_sys) disable iff (rst)
        (modemCtl_ff[7] && $past(modemCtl_ff[7]) && divFull == 21'h10 && sampleTick_ff) ##1
        (modemCtl_ff[7] && divFull == 21'h10)[*4] |-> sampleTick_ff && !$past(sampleTick_ff);
    endproperty
    a_pres_quarter: assert property (p_pres_quarter) else $error("prescale not four");

    property p_pres_bypass;
        @(posedge clk_sys) disable iff (rst)
        (!modemCtl_ff[7] && divFull <= 21'h10) |=> sampleTick_ff;
    endproperty
    a_pres_bypass: assert property (p_pres_bypass) else $error("divide by one stalls");

    property p_start_low;
        @(posedge clk_sys) disable iff (rst)
        pop |=> (txOut_ff == 1'b0 && txState_ff == ufb_pkg::TX_START);
    endproperty
    a_start_low: assert property (p_start_low) else $error("no start bit");

    property p_lsb_first;
        @(posedge clk_sys) disable iff (rst)
        (txState_ff == ufb_pkg::TX_DATA && $past(txState_ff) == ufb_pkg::TX_START)
        |-> txOut_ff == $past(txShift_ff[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first data bit wrong");

    property p_lsr_order;
        @(posedge clk_sys) disable iff (rst)
        (regCs && regRd && regAddr == ufb_pkg::OFS_LINESTAT)
        |=> (!regRdData_ff[6] || regRdData_ff[5]);
    endproperty
    a_lsr_order: assert property (p_lsr_order) else $error("shifter empty with data queued");

    property p_bit_len;
        @(posedge clk_sys) disable iff (rst)
        (txState_ff == ufb_pkg::TX_DATA) |-> (sampCnt_ff < bitLen);
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("bit longer than ratio");

    property p_fifo_full;
        @(posedge clk_sys) disable iff (rst)
        (fifoCount_ff == 5'h10 && !pop) |=> (fifoCount_ff == 5'h10);
    endproperty
    a_fifo_full: assert property (p_fifo_full) else $error("full FIFO count moved");

    property p_mode_fallback;
        @(posedge clk_sys) disable iff (rst)
        (divFrac_ff[5:4] == 2'h3) |-> (bitLen == 6'h10);
    endproperty
    a_mode_fallback: assert property (p_mode_fallback) else $error("pattern 11 not 16X");
endmodule : ufb_fractional_baud_gen_tx

`default_nettype wire

// >>> tb/ufb_rx_model.sv
// Remote serial receiver: decodes each frame seen on txOut.
// Assumes the bench gives the bit length in clk_sys cycles and the frame format.
`timescale 1ns/1ns
`default_nettype none
module ufb_rx_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Line and format
    input wire logic txOut,
    input var int bitClk,
    input var int nBits,
    input var logic parOn,
    // Decoded character
    output var logic [7:0] rxData,
    output var logic rxPar,
    output var logic rxStop,
    output var logic rxDone
);
    logic [7:0] sh = 8'h00;
    initial begin
        rxData = 8'h00;
        rxPar = 1'b0;
        rxStop = 1'b0;
        rxDone = 1'b0;
    end
    // Samples mid-bit, so a bit length off by a tick or two still decodes
    always begin
        @(posedge clk_sys);
        rxDone <= 1'b0;
        if (!rst && txOut === 1'b0) begin
            repeat (bitClk / 2) @(posedge clk_sys);
            sh = 8'h00;
            for (int i = 0; i < nBits; i++) begin
                repeat (bitClk) @(posedge clk_sys);
                sh[i] = txOut;
            end
            if (parOn) begin
                repeat (bitClk) @(posedge clk_sys);
                rxPar <= txOut;
            end
            repeat (bitClk) @(posedge clk_sys);
            rxStop <= txOut;
            rxData <= sh;
            rxDone <= 1'b1;
        end
    end
endmodule : ufb_rx_model
`default_nettype wire

// >>> tb/ufb_fractional_baud_gen_tx_bench.sv
// Bench for one channel: register tasks, tick timing and decoded characters.
// Assumes the register port is synchronous to clk_sys; the serial side ends in ufb_rx_model.
`timescale 1ns/1ns
`default_nettype none
module ufb_fractional_baud_gen_tx_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic regCs = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData, rxData, rd, e;
    logic txOut, sampleTick, rxPar, rxStop, rxDone;
    logic parOn = 1'b0;
    logic [7:0] lcr = 8'h03;
    logic [7:0] expQ[$];
    logic [7:0] fmt[4] = '{8'h1B, 8'h0B, 8'h00, 8'h07};
    int bitClk = 16, nBits = 8, n_mismatch = 0, check_count = 0, cycles = 0, seed = 49567;
    always #4 clk_sys = ~clk_sys;
    ufb_fractional_baud_gen_tx ufb_fractional_baud_gen_tx_i (.clk_sys(clk_sys), .rst(rst),
        .regCs(regCs), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .txOut(txOut), .sampleTick(sampleTick));
    ufb_rx_model ufb_rx_model_i (.clk_sys(clk_sys), .rst(rst), .txOut(txOut), .bitClk(bitClk),
        .nBits(nBits), .parOn(parOn), .rxData(rxData), .rxPar(rxPar), .rxStop(rxStop),
        .rxDone(rxDone));
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        check_count++;
        if (got !== ex) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    // Hang guard: the whole sequence needs about 10000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // Bench model of the far end: every decoded character is compared
    always @(posedge clk_sys) begin
        if (rxDone === 1'b1) begin
            e = (expQ.size() > 0) ? expQ.pop_front() : 8'hXX;
            chk("rx data", {8'h00, e}, {8'h00, rxData});
            chk("stop bit", 16'h0001, {15'h0000, rxStop});
            if (parOn) begin
                chk("parity", {15'h0000, ^e ^ ~lcr[4]}, {15'h0000, rxPar});
            end
        end
    end
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        regCs = 1'b1;
        regWr = w;
        regRd = ~w;
        regAddr = a;
        regWrData = d;
        @(posedge clk_sys);
        #1;
        regCs = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        @(posedge clk_sys);
        #1;
        rd = regRdData;
    endtask : bus
    task automatic setup(input int dv, input logic [7:0] fr, input logic pres, input logic [7:0] lc);
        bus(1'b1, ufb_pkg::OFS_LINECTL, 8'h80);
        bus(1'b1, ufb_pkg::OFS_DATA, dv[7:0]);
        bus(1'b1, ufb_pkg::OFS_DIVHI, dv[15:8]);
        bus(1'b1, ufb_pkg::OFS_DIVFRAC, fr);
        bus(1'b1, ufb_pkg::OFS_LINECTL, lc);
        bus(1'b1, ufb_pkg::OFS_MODEMCTL, {pres, 7'h00});
        lcr = lc;
        nBits = lc[1:0] + 5;
        parOn = lc[3];
        bitClk = ((fr[5:4] == 2'h1) ? 8 : (fr[5:4] == 2'h2) ? 4 : 16) * dv * (pres ? 4 : 1);
    endtask : setup
    // Counts n tick periods, skipping the gap that may straddle a divisor change
    task automatic ticks(input int n, input logic [15:0] ex);
        int c;
        int k;
        c = 0;
        k = 0;
        while (k < n + 2) begin
            @(posedge clk_sys);
            #1;
            if (k >= 2) c++;
            if (sampleTick === 1'b1) k++;
        end
        chk("tick period", ex, c[15:0]);
    endtask : ticks
    // Writes n random bytes; only the first keep of them are expected on the line
    task automatic send(input int n, input int keep);
        int r;
        for (int i = 0; i < n; i++) begin
            r = $random(seed);
            if (i < keep) expQ.push_back(r[7:0] & (8'hFF >> (3 - lcr[1:0])));
            bus(1'b1, ufb_pkg::OFS_DATA, r[7:0]);
        end
        bus(1'b0, ufb_pkg::OFS_LINESTAT, 8'h00);
        chk("busy status", 16'h0000, {8'h00, rd & ((n > 1) ? 8'h60 : 8'h40)});
        for (int t = 0; t < 20000 && expQ.size() != 0; t++) @(posedge clk_sys);
        chk("pending chars", 16'h0000, 16'(expQ.size()));
        repeat (2 * bitClk) @(posedge clk_sys);
        bus(1'b0, ufb_pkg::OFS_LINESTAT, 8'h00);
        chk("idle status", 16'h0060, {8'h00, rd & 8'h60});
    endtask : send
    initial begin
        repeat (20) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        bus(1'b1, ufb_pkg::OFS_LINECTL, 8'h80);
        bus(1'b0, ufb_pkg::OFS_DATA, 8'h00);
        chk("div low", 16'h0001, {8'h00, rd});
        bus(1'b0, ufb_pkg::OFS_DIVHI, 8'h00);
        chk("div high", 16'h0000, {8'h00, rd});
        bus(1'b0, ufb_pkg::OFS_DIVFRAC, 8'h00);
        chk("div frac", 16'h0000, {8'h00, rd});
        bus(1'b0, 3'h7, 8'h00);
        chk("unmapped", 16'h0000, {8'h00, rd});
        bus(1'b0, ufb_pkg::OFS_LINESTAT, 8'h00);
        chk("reset status", 16'h0060, {8'h00, rd & 8'h60});
        ticks(4, 16'h0004);
        $display("test reset done");
        setup(3, 8'h00, 1'b0, 8'h03);
        ticks(8, 16'h0018);
        setup(3, 8'h00, 1'b1, 8'h03);
        ticks(4, 16'h0030);
        setup(1, 8'h00, 1'b1, 8'h03);
        ticks(4, 16'h0010);
        setup(3, 8'hC5, 1'b0, 8'h03);
        ticks(16, 16'h0035);
        setup(257, 8'h00, 1'b0, 8'h03);
        ticks(1, 16'h0101);
        $display("test rate done");
        for (int m = 0; m < 4; m++) begin
            setup(2, {2'h0, m[1:0], 4'h0}, 1'b0, 8'h03);
            send(1, 1);
        end
        $display("test sampling done");
        foreach (fmt[f]) begin
            setup(1, 8'h00, 1'b0, fmt[f]);
            send(3, 3);
        end
        $display("test format done");
        setup(2, 8'h00, 1'b0, 8'h03);
        send(18, 17);
        $display("test fifo done");
        wrap_up();
    end
endmodule : ufb_fractional_baud_gen_tx_bench
`default_nettype wire
